// ---- inc/data_memory_space_pkg.sv ----
// Purpose: shared constants and types for the data memory space decoder
// Assumes: 8-bit cpu core on one 50 MHz clock
// Notes:   phase lengths of the external bus cycle are counts of clk cycles
package data_memory_space_pkg;
  // ***********************
  // program space
  // ***********************
  localparam int          CODE_AW       = 16;
  localparam logic [15:0] RESET_VECTOR  = 16'h0000;
  localparam logic [15:0] VECTOR_BASE   = 16'h0003;
  localparam int          VECTOR_SHIFT  = 3;
  // ***********************
  // internal data space
  // ***********************
  localparam int          IRAM_DEPTH    = 256;
  localparam logic [7:0]  LOWER_TOP     = 8'h7f;
  localparam logic [7:0]  BANK_BASE     = 8'h00;
  localparam logic [7:0]  BITAREA_BASE  = 8'h20;
  localparam int          BANK_SEL_POS  = 3;
  localparam int          SFR_BIT_POS   = 3;
  // ***********************
  // expanded ram and external bus
  // ***********************
  localparam int          ERAM_DEPTH    = 1024;
  localparam int          ERAM_AW       = 10;
  localparam logic [15:0] ERAM_LAST     = 16'h03ff;
  localparam logic [7:0]  PORT0_FILL    = 8'hff;
  localparam logic [7:0]  UNMAPPED_READ = 8'hff;
  localparam int          ALE_SEL_P35   = 0;
  localparam int          ALE_SEL_P41   = 1;
  localparam logic [2:0]  ADDR_CYCLES   = 3'h2;
  localparam logic [2:0]  LATCH_CYCLES  = 3'h1;
  localparam logic [2:0]  STROBE_CYCLES = 3'h4;
  localparam logic [2:0]  HOLD_CYCLES   = 3'h1;

  typedef struct packed {
    logic        write;
    logic        wide;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } ext_req_t;

  typedef struct packed {
    logic       indirect;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } iram_req_t;

  typedef enum logic [4:0] {
    BUS_IDLE   = 5'h01,
    BUS_ADDR   = 5'h02,
    BUS_LATCH  = 5'h04,
    BUS_STROBE = 5'h08,
    BUS_HOLD   = 5'h10
  } bus_state_t;
endpackage : data_memory_space_pkg

// ---- src/data_memory_space_decoder.sv ----
// Purpose: memory space decoding, internal ram, expanded ram and external data bus
// Assumes: one clock, requests from core logic on the same clock, port 0 read from a pin
// Notes:   no external program bus exists
//
// Functional notes
// - program space is read-only, 64k, on chip; never fetched externally.
// - fetching starts at address 0000H after reset.
// - interrupt vectors sit at 0003H plus eight bytes per source.
// - 256 bytes of scratch-pad ram with 8-bit addresses.
// - above 7FH direct reaches sfr space, indirect reaches upper ram.
// - lowest 32 bytes form four banks of eight registers chosen by status bits.
// - 16 bytes above the banks are bit addressable as bits 00H-7FH.
// - lower 128 bytes direct or indirect; upper 128 bytes indirect only.
// - sfrs only direct; addresses ending 0H or 8H also bit accessible.
// - external transfers use 8-bit or 16-bit pointer addresses with read and write strobes.
// - select bit 1 goes to external bus, 0 to expanded ram.
// - expanded ram 0000H-03FFH; its accesses leave all bus pins unchanged.
// - 8-bit indirect access keeps port 2 latch contents on port 2.
// - 16-bit access drives high address on port 2 for whole cycle.
// - low address multiplexed on port 0, valid at latch strobe fall.
// - write data on port 0 from write strobe fall until after release.
// - port 0 sampled just before read strobe release; memory drives it. Code uses the pin value from one clock after strobe fall.
// - any external bus access loads 0FFH into port 0 latch; expanded ram accesses leave it unchanged.
// - latch strobe on port3 bit5 or port4 bit1 by two select bits.
// - active-low read and write strobes on port3 bit7 and bit6.
// - bank select 00,01,10,11 maps to 00H,08H,10H,18H register groups.
`timescale 1ns/1ps
module data_memory_space_decoder
  import data_memory_space_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              clkEn,
  // program fetch
  input  wire logic              fetchAdvance,
  input  wire logic              jumpValid,
  input  wire logic [15:0]       jumpAddr,
  input  wire logic              intTake,
  input  wire logic [2:0]        intSource,
  output logic [CODE_AW-1:0]     codeAddr_ff,
  // internal data access
  input  wire logic              bank_select_hi,
  input  wire logic              bank_select_lo,
  input  wire logic              regValid,
  input  wire logic [2:0]        regIdx,
  input  wire logic              regWrite,
  input  wire logic [7:0]        regWdata,
  input  wire logic              iramValid,
  input  wire iram_req_t         iramReq,
  input  wire logic              bitValid,
  input  wire logic [7:0]        bitAddr,
  input  wire logic              bitWrite,
  input  wire logic              bitWdata,
  input  wire logic [7:0]        sfrRdata,
  output logic                   dataAck_ff,
  output logic [7:0]             dataRdata_ff,
  output logic                   bitRdata_ff,
  output logic                   sfrValid_ff,
  output logic                   sfrWrite_ff,
  output logic                   sfrBitOp_ff,
  output logic [2:0]             sfrBitPos_ff,
  output logic [7:0]             sfrAddr_ff,
  output logic [7:0]             sfrWdata_ff,
  // move-external requests
  input  wire logic              external_memory_select,
  input  wire logic [1:0]        aleSelect,
  input  wire logic              xferValid,
  input  wire ext_req_t          xferReq,
  output logic                   xferBusy_ff,
  output logic                   xferDone_ff,
  output logic [7:0]             xferRdata_ff,
  // port latches from the sfr side
  input  wire logic              port0LatchWe,
  input  wire logic [7:0]        port0LatchWdata,
  input  wire logic [7:0]        port2Latch,
  input  wire logic              port3Bit5Latch,
  input  wire logic              port3Bit6Latch,
  input  wire logic              port3Bit7Latch,
  input  wire logic              port4Bit1Latch,
  output logic [7:0]             port0Latch_ff,
  // pins
  input  wire logic [7:0]        port0In,
  output logic [7:0]             port0Out_ff,
  output logic [7:0]             port0Oe_ff,
  output logic [7:0]             port2Out_ff,
  output logic                   port3Bit5Out_ff,
  output logic                   port3Bit6Out_ff,
  output logic                   port3Bit7Out_ff,
  output logic                   port4Bit1Out_ff
);

  // ***********************
  // functions
  // ***********************
  function automatic logic [15:0] vectorAddr(input logic [2:0] src);
    vectorAddr = VECTOR_BASE + (16'({13'h0000, src}) << VECTOR_SHIFT);
  endfunction : vectorAddr

  function automatic logic [7:0] bitByteAddr(input logic [7:0] ba);
    if (ba <= LOWER_TOP) begin
      bitByteAddr = BITAREA_BASE + {4'h0, ba[6:3]};
    end else begin
      bitByteAddr = {ba[7:3], 3'h0};
    end
  endfunction : bitByteAddr

  function automatic logic eramHit(input logic [15:0] a);
    eramHit = (a <= ERAM_LAST);
  endfunction : eramHit

  // ***********************
  // reset and pin synchronisers
  // ***********************
  logic [1:0] rstSync_ff;
  logic       rstN;
  logic [7:0] p0Meta_ff;
  logic [7:0] p0Sync_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstSync_ff <= 2'h0;
    end else begin
      rstSync_ff <= {rstSync_ff[0], 1'b1};
    end
  end
  assign rstN = rstSync_ff[1];

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      p0Meta_ff <= 8'h00;
      p0Sync_ff <= 8'h00;
    end else if (clkEn) begin
      p0Meta_ff <= port0In;
      p0Sync_ff <= p0Meta_ff;
    end
  end

  // ***********************
  // program fetch address
  // ***********************
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      codeAddr_ff <= RESET_VECTOR;
    end else if (clkEn) begin
      if (intTake) begin
        codeAddr_ff <= vectorAddr(intSource);
      end else if (jumpValid) begin
        codeAddr_ff <= jumpAddr;
      end else if (fetchAdvance) begin
        codeAddr_ff <= codeAddr_ff + 16'h0001;
      end
    end
  end

  // ***********************
  // internal data decode
  // ***********************
  logic [7:0] iram [IRAM_DEPTH];
  logic       accValid;
  logic       accWrite;
  logic       accBit;
  logic       accSfr;
  logic [7:0] accAddr;
  logic [7:0] accWdata;
  logic [2:0] accBitPos;

  always_comb begin
    accValid  = 1'b0;
    accWrite  = 1'b0;
    accBit    = 1'b0;
    accSfr    = 1'b0;
    accAddr   = 8'h00;
    accWdata  = 8'h00;
    accBitPos = 3'h0;
    if (regValid) begin
      accValid = 1'b1;
      accWrite = regWrite;
      accAddr  = BANK_BASE + {3'h0, bank_select_hi, bank_select_lo, regIdx};
      accWdata = regWdata;
    end else if (iramValid) begin
      accValid = 1'b1;
      accWrite = iramReq.write;
      accAddr  = iramReq.addr;
      accWdata = iramReq.wdata;
      accSfr   = !iramReq.indirect && (iramReq.addr > LOWER_TOP);
    end else if (bitValid) begin
      accValid  = 1'b1;
      accWrite  = bitWrite;
      accBit    = 1'b1;
      accAddr   = bitByteAddr(bitAddr);
      accBitPos = bitAddr[SFR_BIT_POS-1:0];
      accSfr    = (bitAddr > LOWER_TOP);
    end
  end

  always_ff @(posedge clk) begin
    if (clkEn && accValid && accWrite && !accSfr) begin
      if (accBit) begin
        iram[accAddr][accBitPos] <= bitWdata;
      end else begin
        iram[accAddr] <= accWdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      dataAck_ff   <= 1'b0;
      dataRdata_ff <= 8'h00;
      bitRdata_ff  <= 1'b0;
    end else if (clkEn) begin
      dataAck_ff <= accValid;
      if (accValid && !accSfr) begin
        dataRdata_ff <= iram[accAddr];
        bitRdata_ff  <= iram[accAddr][accBitPos];
      end else if (accValid) begin
        dataRdata_ff <= sfrRdata;
        bitRdata_ff  <= sfrRdata[accBitPos];
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      sfrValid_ff  <= 1'b0;
      sfrWrite_ff  <= 1'b0;
      sfrBitOp_ff  <= 1'b0;
      sfrBitPos_ff <= 3'h0;
      sfrAddr_ff   <= 8'h00;
      sfrWdata_ff  <= 8'h00;
    end else if (clkEn) begin
      sfrValid_ff  <= accValid && accSfr;
      sfrWrite_ff  <= accValid && accSfr && accWrite;
      sfrBitOp_ff  <= accBit;
      sfrBitPos_ff <= accBitPos;
      sfrAddr_ff   <= accAddr;
      sfrWdata_ff  <= accBit ? {7'h00, bitWdata} : accWdata;
    end
  end

  // ***********************
  // expanded ram
  // ***********************
  logic [7:0] eram [ERAM_DEPTH];
  logic       eramStart;
  logic       extStart;

  assign eramStart = clkEn && xferValid && !xferBusy_ff && !external_memory_select;
  assign extStart  = xferValid && !xferBusy_ff && external_memory_select;

  always_ff @(posedge clk) begin
    if (eramStart && xferReq.write && eramHit(xferReq.addr)) begin
      eram[xferReq.addr[ERAM_AW-1:0]] <= xferReq.wdata;
    end
  end

  // ***********************
  // external bus sequencer
  // ***********************
  bus_state_t busState_ff;
  logic [2:0] phaseCnt_ff;
  ext_req_t   cur_ff;
  logic       phaseEnd;

  assign phaseEnd = (phaseCnt_ff == 3'h1);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      busState_ff <= BUS_IDLE;
      phaseCnt_ff <= 3'h0;
      cur_ff      <= '0;
    end else if (clkEn) begin
      case (busState_ff)
        BUS_IDLE: begin
          if (extStart) begin
            cur_ff      <= xferReq;
            busState_ff <= BUS_ADDR;
            phaseCnt_ff <= ADDR_CYCLES;
          end
        end
        BUS_ADDR: begin
          phaseCnt_ff <= phaseCnt_ff - 3'h1;
          if (phaseEnd) begin
            busState_ff <= BUS_LATCH;
            phaseCnt_ff <= LATCH_CYCLES;
          end
        end
        BUS_LATCH: begin
          phaseCnt_ff <= phaseCnt_ff - 3'h1;
          if (phaseEnd) begin
            busState_ff <= BUS_STROBE;
            phaseCnt_ff <= STROBE_CYCLES;
          end
        end
        BUS_STROBE: begin
          phaseCnt_ff <= phaseCnt_ff - 3'h1;
          if (phaseEnd) begin
            busState_ff <= BUS_HOLD;
            phaseCnt_ff <= HOLD_CYCLES;
          end
        end
        BUS_HOLD: begin
          phaseCnt_ff <= phaseCnt_ff - 3'h1;
          if (phaseEnd) begin
            busState_ff <= BUS_IDLE;
          end
        end
        default: begin
          busState_ff <= BUS_IDLE;
          phaseCnt_ff <= 3'h0;
        end
      endcase
    end
  end

  // ***********************
  // move-external handshake and read data
  // ***********************
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      xferBusy_ff  <= 1'b0;
      xferDone_ff  <= 1'b0;
      xferRdata_ff <= 8'h00;
    end else if (clkEn) begin
      xferDone_ff <= 1'b0;
      if (eramStart) begin
        xferDone_ff <= 1'b1;
        if (!xferReq.write) begin
          xferRdata_ff <= eramHit(xferReq.addr) ? eram[xferReq.addr[ERAM_AW-1:0]] : UNMAPPED_READ;
        end
      end else if (extStart) begin
        xferBusy_ff <= 1'b1;
      end else if (busState_ff == BUS_STROBE && phaseEnd && !cur_ff.write) begin
        xferRdata_ff <= p0Sync_ff;
      end else if (busState_ff == BUS_HOLD && phaseEnd) begin
        xferBusy_ff <= 1'b0;
        xferDone_ff <= 1'b1;
      end
    end
  end

  // ***********************
  // port 0 latch
  // ***********************
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      port0Latch_ff <= PORT0_FILL;
    end else if (clkEn) begin
      if (extStart) begin
        port0Latch_ff <= PORT0_FILL;
      end else if (port0LatchWe) begin
        port0Latch_ff <= port0LatchWdata;
      end
    end
  end

  // ***********************
  // bus pins
  // ***********************
  logic aleLevel;
  logic rdLevelN;
  logic wrLevelN;

  always_comb begin
    aleLevel = (busState_ff == BUS_ADDR);
    rdLevelN = !(busState_ff == BUS_STROBE && !cur_ff.write);
    wrLevelN = !(busState_ff == BUS_STROBE && cur_ff.write);
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      port0Out_ff <= 8'h00;
      port0Oe_ff  <= 8'h00;
    end else if (clkEn) begin
      case (busState_ff)
        BUS_ADDR, BUS_LATCH: begin
          port0Out_ff <= cur_ff.addr[7:0];
          port0Oe_ff  <= 8'hff;
        end
        BUS_STROBE: begin
          port0Out_ff <= cur_ff.wdata;
          port0Oe_ff  <= cur_ff.write ? 8'hff : 8'h00;
        end
        BUS_HOLD: begin
          port0Out_ff <= cur_ff.wdata;
          port0Oe_ff  <= cur_ff.write ? 8'hff : 8'h00;
        end
        default: begin
          port0Out_ff <= port0Latch_ff;
          port0Oe_ff  <= ~port0Latch_ff;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      port2Out_ff <= 8'hff;
    end else if (clkEn) begin
      if (busState_ff != BUS_IDLE && cur_ff.wide) begin
        port2Out_ff <= cur_ff.addr[15:8];
      end else begin
        port2Out_ff <= port2Latch;
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      port3Bit5Out_ff <= 1'b1;
      port3Bit6Out_ff <= 1'b1;
      port3Bit7Out_ff <= 1'b1;
      port4Bit1Out_ff <= 1'b1;
    end else if (clkEn) begin
      port3Bit5Out_ff <= aleSelect[ALE_SEL_P35] ? aleLevel : port3Bit5Latch;
      port4Bit1Out_ff <= aleSelect[ALE_SEL_P41] ? aleLevel : port4Bit1Latch;
      port3Bit6Out_ff <= port3Bit6Latch && wrLevelN;
      port3Bit7Out_ff <= port3Bit7Latch && rdLevelN;
    end
  end

endmodule : data_memory_space_decoder

// ---- testbench/data_memory_space_decoder_tb.sv ----
// Purpose: self-checking bench for the data memory space decoder
// Assumes: ram model on the multiplexed bus, pull-up on port 0
// Notes:   inputs change 1 ns after the rising clock edge
`timescale 1ns/1ps
module data_memory_space_decoder_tb import data_memory_space_pkg::*;;
  logic        clk = 1'b0, nrst = 1'b0, slowRd = 1'b0, ramDrive;
  logic        fetchAdvance, jumpValid, intTake, regValid, regWrite, iramValid, bitValid, bitWrite, bitWdata;
  logic        bank_select_hi, bank_select_lo, external_memory_select, xferValid, port0LatchWe;
  logic        dataAck_ff, bitRdata_ff, sfrValid_ff, xferDone_ff, port3Bit6Out_ff, port3Bit7Out_ff, port4Bit1Out_ff;
  logic        sfrWrite_ff, sfrBitOp_ff, clkEn = 1'b1;
  logic [2:0]  intSource, regIdx, sfrBitPos_ff;
  logic [4:0]  sf;
  logic [1:0]  aleSelect;
  logic [7:0]  regWdata, bitAddr, sfrRdata, port0LatchWdata, port2Latch, port0In, ramData, rd, xr;
  logic [7:0]  dataRdata_ff, xferRdata_ff, port0Latch_ff, port0Out_ff, port0Oe_ff, port2Out_ff;
  logic [7:0]  sfrAddr_ff, sfrWdata_ff;
  logic [15:0] jumpAddr, codeAddr_ff, sq;
  logic        ack, sv, rb;
  iram_req_t   iramReq;
  ext_req_t    xferReq;
  int          errTotal = 0, checks = 0, cyc = 0;

  assign port0In = (port0Oe_ff & port0Out_ff) | (~port0Oe_ff & (ramDrive ? ramData : 8'hff));
  always #10 clk = ~clk;

  data_memory_space_decoder i_dut (
    .clk, .nrst, .clkEn, .fetchAdvance, .jumpValid, .jumpAddr, .intTake, .intSource, .codeAddr_ff,
    .bank_select_hi, .bank_select_lo, .regValid, .regIdx, .regWrite, .regWdata, .iramValid, .iramReq,
    .bitValid, .bitAddr, .bitWrite, .bitWdata, .sfrRdata, .dataAck_ff, .dataRdata_ff, .bitRdata_ff,
    .sfrValid_ff, .sfrWrite_ff, .sfrBitOp_ff, .sfrBitPos_ff, .sfrAddr_ff, .sfrWdata_ff,
    .external_memory_select, .aleSelect, .xferValid, .xferReq, .xferBusy_ff(), .xferDone_ff, .xferRdata_ff,
    .port0LatchWe, .port0LatchWdata, .port2Latch, .port3Bit5Latch(1'b1), .port3Bit6Latch(1'b1),
    .port3Bit7Latch(1'b1), .port4Bit1Latch(1'b1), .port0Latch_ff, .port0In, .port0Out_ff, .port0Oe_ff,
    .port2Out_ff, .port3Bit5Out_ff(), .port3Bit6Out_ff, .port3Bit7Out_ff, .port4Bit1Out_ff
  );
  ext_ram_model i_ram (
    .ale(port4Bit1Out_ff), .rdN(port3Bit7Out_ff), .wrN(port3Bit6Out_ff), .busIn(port0In),
    .addrHi(port2Out_ff), .slow(slowRd), .drive(ramDrive), .dataOut(ramData)
  );

  // ****
  // tasks
  // ****
  task automatic conclude();
    $display("checks=%0d errors=%0d", checks, errTotal);
    if (errTotal == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errTotal++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  // k: 0 register, 1 direct byte, 2 indirect byte, 3 bit
  task automatic dacc(input logic [1:0] k, input logic w, input logic [7:0] a, input logic [7:0] d);
    regValid = (k == 2'h0);
    iramValid = (k == 2'h1 || k == 2'h2);
    bitValid = (k == 2'h3);
    {regWrite, bitWrite, regIdx, regWdata, bitAddr, bitWdata} = {w, w, a[2:0], d, a, d[0]};
    iramReq = '{k == 2'h2, w, a, d};
    tick();
    {ack, rd, rb, sv} = {dataAck_ff, dataRdata_ff, bitRdata_ff, sfrValid_ff};
    {sq, sf} = {sfrAddr_ff, sfrWdata_ff, sfrWrite_ff, sfrBitOp_ff, sfrBitPos_ff};
    {regValid, iramValid, bitValid} = 3'h0;
    tick();
    chk(ack, 1'b1);
  endtask : dacc

  task automatic mx(input logic w, input logic wide, input logic [15:0] a, input logic [7:0] d);
    int n = 0;
    xferValid = 1'b1;
    xferReq = '{w, wide, a, d};
    tick();
    xferValid = 1'b0;
    while (xferDone_ff !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    chk(n < 20, 1'b1);
    xr = xferRdata_ff;
    tick();
  endtask : mx

  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      errTotal++;
      conclude();
    end
  end

  // ****
  // tests
  // ****
  initial begin
    {fetchAdvance, jumpValid, intTake, regValid, iramValid, bitValid, xferValid, port0LatchWe} = 8'h00;
    {regWrite, bitWrite, bitWdata, bank_select_hi, bank_select_lo, external_memory_select} = 6'h00;
    {intSource, regIdx, regWdata, bitAddr, port0LatchWdata} = 30'h0;
    {jumpAddr, sfrRdata, port2Latch, aleSelect} = {16'h1234, 8'h3c, 8'hc3, 2'h3};
    iramReq = '0;
    xferReq = '0;
    repeat (10) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (3) tick();
    chk(codeAddr_ff, 16'h0000);
    fetchAdvance = 1'b1;
    tick();
    tick();
    chk(codeAddr_ff, 16'h0002);
    clkEn = 1'b0;
    tick();
    tick();
    chk(codeAddr_ff, 16'h0002);
    clkEn = 1'b1;
    {fetchAdvance, jumpValid, intTake} = 3'h3;
    for (int s = 0; s < 8; s++) begin
      intSource = 3'(s);
      tick();
      chk(codeAddr_ff, 16'h0003 + 16'(8 * s));
    end
    intTake = 1'b0;
    tick();
    chk(codeAddr_ff, 16'h1234);
    jumpValid = 1'b0;
    for (int b = 0; b < 4; b++) begin
      {bank_select_hi, bank_select_lo} = 2'(b);
      dacc(2'h0, 1'b1, 8'h05, 8'h40 + 8'(b));
      dacc(2'h1, 1'b0, 8'(8 * b + 5), 8'h00);
      chk(rd, 8'h40 + 8'(b));
    end
    dacc(2'h2, 1'b0, 8'h0d, 8'h00);
    chk(rd, 8'h41);
    dacc(2'h2, 1'b1, 8'h90, 8'ha5);
    chk(sv, 1'b0);
    dacc(2'h1, 1'b1, 8'h90, 8'h11);
    chk(sv, 1'b1);
    chk(sq, 16'h9011);
    chk(sf, 5'h10);
    dacc(2'h1, 1'b0, 8'h90, 8'h00);
    chk(rd, 8'h3c);
    dacc(2'h2, 1'b0, 8'h90, 8'h00);
    chk(rd, 8'ha5);
    dacc(2'h1, 1'b1, 8'h21, 8'h00);
    dacc(2'h3, 1'b1, 8'h0b, 8'h01);
    dacc(2'h1, 1'b0, 8'h21, 8'h00);
    chk(rd, 8'h08);
    dacc(2'h3, 1'b0, 8'h8a, 8'h00);
    chk({sv, rb}, 2'h3);
    chk(sq, 16'h8800);
    chk(sf, 5'h0a);
    port0LatchWe = 1'b1;
    port0LatchWdata = 8'h5a;
    tick();
    port0LatchWe = 1'b0;
    tick();
    mx(1'b1, 1'b1, ERAM_LAST, 8'h77);
    mx(1'b0, 1'b1, ERAM_LAST, 8'h00);
    chk(xr, 8'h77);
    mx(1'b0, 1'b1, ERAM_LAST + 16'h0001, 8'h00);
    chk(xr, 8'hff);
    chk(port0Latch_ff, 8'h5a);
    external_memory_select = 1'b1;
    mx(1'b1, 1'b1, 16'h1234, 8'h5a);
    chk(port0Latch_ff, 8'hff);
    mx(1'b1, 1'b0, 16'h00a7, 8'h96);
    slowRd = 1'b1;
    mx(1'b0, 1'b1, 16'hc3a7, 8'h00);
    chk(xr, 8'h96);
    slowRd = 1'b0;
    mx(1'b0, 1'b1, 16'h1234, 8'h00);
    chk(xr, 8'h5a);
    external_memory_select = 1'b0;
    mx(1'b0, 1'b1, ERAM_LAST, 8'h00);
    chk(xr, 8'h77);
    conclude();
  end
endmodule : data_memory_space_decoder_tb

// ---- testbench/data_memory_space_monitor.sv ----
// Purpose: port assertions for the data memory space decoder
// Assumes: requests only while the decoder is idle, latch bits of port 3 held high
// Notes:   latch strobe watched on port3 bit5
`timescale 1ns/1ps
module data_memory_space_monitor
  import data_memory_space_pkg::*;
(
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       clkEn,
  input wire logic       regValid,
  input wire logic       iramValid,
  input wire iram_req_t  iramReq,
  input wire logic       sfrValid_ff,
  input wire logic       external_memory_select,
  input wire logic       xferValid,
  input wire ext_req_t   xferReq,
  input wire logic       xferBusy_ff,
  input wire logic       xferDone_ff,
  input wire logic [7:0] port0Out_ff,
  input wire logic [7:0] port0Oe_ff,
  input wire logic [7:0] port2Out_ff,
  input wire logic       port3Bit5Out_ff,
  input wire logic       port3Bit6Out_ff,
  input wire logic       port3Bit7Out_ff
);
  // ****
  // request capture
  // ****
  logic       xferTake;
  logic [7:0] reqHi_ff;
  logic [7:0] reqLo_ff;
  logic [7:0] reqData_ff;
  assign xferTake = clkEn && xferValid && !xferBusy_ff;
  always_ff @(posedge clk) begin
    if (xferTake && external_memory_select) begin
      reqHi_ff   <= xferReq.addr[15:8];
      reqLo_ff   <= xferReq.addr[7:0];
      reqData_ff <= xferReq.wdata;
    end
  end
  // ****
  // checks
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_RW_EXCL: assert property (port3Bit6Out_ff || port3Bit7Out_ff)
    else $error("both strobes low");
  AST_EXT_LEN: assert property (xferTake && external_memory_select |=> xferBusy_ff[*8] ##1 (!xferBusy_ff && xferDone_ff))
    else $error("external cycle length wrong");
  AST_WIDE_P2: assert property (xferTake && external_memory_select && xferReq.wide |=> ##1 (port2Out_ff == reqHi_ff)[*8])
    else $error("high address not held on port 2");
  AST_ERAM_QUIET: assert property (xferTake && !external_memory_select |=> xferDone_ff && !xferBusy_ff
      && $stable(port0Out_ff) && $stable(port0Oe_ff) && $stable(port2Out_ff) && $stable(port3Bit5Out_ff)
      && $stable(port3Bit6Out_ff) && $stable(port3Bit7Out_ff))
    else $error("expanded ram access moved bus pins");
  AST_ALE_ADDR: assert property (xferBusy_ff && $fell(port3Bit5Out_ff) |-> port0Oe_ff == 8'hff && port0Out_ff == reqLo_ff)
    else $error("low address not on port 0 at latch fall");
  AST_ALE_FIRST: assert property ($fell(port3Bit6Out_ff) || $fell(port3Bit7Out_ff) |-> $past(port3Bit5Out_ff, 2) && !port3Bit5Out_ff)
    else $error("strobe without preceding latch pulse");
  AST_WR_DATA: assert property (!port3Bit6Out_ff || $rose(port3Bit6Out_ff) |-> port0Oe_ff == 8'hff && port0Out_ff == reqData_ff)
    else $error("write data not held around strobe");
  AST_RD_LEN: assert property ($fell(port3Bit7Out_ff) |-> (!port3Bit7Out_ff && port0Oe_ff == 8'h00)[*4] ##1 port3Bit7Out_ff)
    else $error("read strobe shape wrong");
  AST_INDIRECT_RAM: assert property (clkEn && iramValid && !regValid && iramReq.indirect |=> !sfrValid_ff)
    else $error("indirect access reached sfr side");
  AST_DIRECT_SFR: assert property (clkEn && iramValid && !regValid && !iramReq.indirect && iramReq.addr > LOWER_TOP |=> sfrValid_ff)
    else $error("direct upper access missed sfr side");
endmodule : data_memory_space_monitor

bind data_memory_space_decoder data_memory_space_monitor i_mon (
  .clk, .nrst, .clkEn, .regValid, .iramValid, .iramReq, .sfrValid_ff, .external_memory_select, .xferValid,
  .xferReq, .xferBusy_ff, .xferDone_ff, .port0Out_ff, .port0Oe_ff, .port2Out_ff, .port3Bit5Out_ff,
  .port3Bit6Out_ff, .port3Bit7Out_ff
);

// ---- testbench/ext_ram_model.sv ----
// Purpose: external data ram behind a transparent address latch
// Assumes: active-low strobes, latch open while the strobe input is high
// Notes:   slow delays read data by half a clock cycle
`timescale 1ns/1ps
module ext_ram_model (
  input  wire logic       ale,
  input  wire logic       rdN,
  input  wire logic       wrN,
  input  wire logic [7:0] busIn,
  input  wire logic [7:0] addrHi,
  input  wire logic       slow,
  output logic            drive,
  output logic [7:0]      dataOut
);
  logic [7:0] mem [0:65535];
  logic [7:0] addrLo;
  initial drive = 1'b0;
  initial dataOut = 8'h00;
  always @(ale or busIn) if (ale) addrLo = busIn;
  always @(posedge wrN) mem[{addrHi, addrLo}] = busIn;
  always @(negedge rdN) begin
    if (slow) #10;
    dataOut = mem[{addrHi, addrLo}];
    drive = !rdN;
  end
  always @(posedge rdN) drive = 1'b0;
endmodule : ext_ram_model
